// file: core/time_base_pkg.sv
// constants for the time base interrupt timer
package time_base_pkg;
  localparam int ADDR_W = 8;
  // byte offsets of the registers
  localparam logic [7:0] OFF_CONTROL = 8'h36;
  localparam logic [7:0] OFF_MODE = 8'h38;
  localparam logic [7:0] OFF_STATUS = 8'h3c;
  localparam logic [7:0] OFF_MASK = 8'h40;
  localparam logic [7:0] OFF_DIVIDER = 8'h44;
  // control field positions
  localparam int ENABLE_BIT = 3;
  localparam int RATE_LSB = 0;
  localparam int RATE_W = 3;
  localparam int PRESCALE_BIT = 4;
  // reset values
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [0:0] MASK_RST = 1'h0;
  // high and low clock taps per rate code 0..7 (bit index of divider = exponent-1)
  localparam int DIV_W = 23;
  localparam int HIGH_EXP [8] = '{23, 21, 16, 14, 13, 12, 11, 9};
  localparam int LOW_EXP [8] = '{15, 13, 8, 6, 5, 4, 3, 1};
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_IDLE = 2'h1,
    MODE_SLOW = 2'h3,
    MODE_SLEEP = 2'h2
  } run_mode_t;
endpackage

// file: core/time_base_interrupt_timer.sv
// time base interrupt timer with avalon-mm register slave
//
// The Avalon-MM register port was decided locally.
module time_base_interrupt_timer
(
  input wire logic clk,
  input wire logic rst,
  input wire logic lowClockTick,
  input wire logic [time_base_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic [1:0] response,
  output logic timeBaseInterrupt,
  output logic irq
);
  import time_base_pkg::*;

  logic [7:0] control_q;
  logic [1:0] mode_q;
  logic [0:0] status_q;
  logic [0:0] mask_q;
  logic [DIV_W-1:0] highDiv_q;
  logic [DIV_W-1:0] lowDiv_q;
  logic lowSync1_q, lowSync2_q, lowSync3_q;
  logic tap, tapPrev_q;
  logic [3:0] selPrev_q;
  logic busy_q;
  logic fallEvent;
  logic accept;
  logic useLow;
  logic [RATE_W-1:0] rate;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] off);
    hit = (a == off);
  endfunction

  // one wait cycle: request accepted on its second edge
  assign accept = (read | write) & busy_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (read | write) & ~busy_q;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= ~((read | write) & ~busy_q);
    end
  end

  // low clock tick is asynchronous: two flops before use
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lowSync1_q <= 1'b0;
      lowSync2_q <= 1'b0;
      lowSync3_q <= 1'b0;
    end else begin
      lowSync1_q <= lowClockTick;
      lowSync2_q <= lowSync1_q;
      lowSync3_q <= lowSync2_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      highDiv_q <= '0;
      lowDiv_q <= '0;
    end else begin
      highDiv_q <= highDiv_q + DIV_W'(1);
      if (lowSync2_q & ~lowSync3_q) begin
        lowDiv_q <= lowDiv_q + DIV_W'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      control_q <= CONTROL_RST;
      mode_q <= MODE_RST;
      mask_q <= MASK_RST;
    end else if (accept && write && byteenable[0]) begin
      if (hit(address, OFF_CONTROL)) begin
        control_q <= writedata[7:0];
      end else if (hit(address, OFF_MODE)) begin
        mode_q <= writedata[1:0];
      end else if (hit(address, OFF_MASK)) begin
        mask_q <= writedata[0:0];
      end
    end
  end

  // slow and sleep run only from the low clock
  assign useLow = control_q[PRESCALE_BIT] | mode_q[1];
  // codes above 1 are invalid in slow/sleep: forced to code 1
  assign rate = (mode_q[1] && control_q[RATE_LSB+:RATE_W] > 3'h1)
              ? 3'h1 : control_q[RATE_LSB+:RATE_W];

  always_comb begin
    tap = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (rate == 3'(i)) begin
        tap = useLow ? lowDiv_q[LOW_EXP[i]-1] : highDiv_q[HIGH_EXP[i]-1];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tapPrev_q <= 1'b0;
    end else begin
      tapPrev_q <= tap;
    end
  end

  // a new tap source is watched one cycle before its edges count
  // so switching rate or clock at enable cannot fake a falling edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      selPrev_q <= 4'h0;
    end else begin
      selPrev_q <= {useLow, rate};
    end
  end

  assign fallEvent = control_q[ENABLE_BIT] & tapPrev_q & ~tap
                   & (selPrev_q == {useLow, rate});

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timeBaseInterrupt <= 1'b0;
    end else begin
      timeBaseInterrupt <= fallEvent;
    end
  end

  // sticky status; set wins over read clear
  // clear only what the read returned, so a set during the wait survives
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_q <= 1'b0;
    end else if (timeBaseInterrupt) begin
      status_q <= 1'b1;
    end else if (accept && read && hit(address, OFF_STATUS)
                 && readdata[0]) begin
      status_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_q & mask_q);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readdata <= '0;
      response <= 2'h0;
    end else if ((read | write) & ~busy_q) begin
      response <= 2'h0;
      readdata <= '0;
      if (hit(address, OFF_CONTROL)) begin
        readdata <= {24'h0, control_q};
      end else if (hit(address, OFF_MODE)) begin
        readdata <= {30'h0, mode_q};
      end else if (hit(address, OFF_STATUS)) begin
        readdata <= {31'h0, status_q};
      end else if (hit(address, OFF_MASK)) begin
        readdata <= {31'h0, mask_q};
      end else if (hit(address, OFF_DIVIDER)) begin
        readdata <= {9'h0, highDiv_q};
      end else begin
        // unmapped: decode error, reads zero
        response <= 2'h3;
      end
    end
  end

  a_disabled_silent: assert property (@(posedge clk) disable iff (rst)
    !control_q[ENABLE_BIT] |=> !timeBaseInterrupt)
    else $error("interrupt while disabled");

  a_edge_pulse: assert property (@(posedge clk) disable iff (rst)
    (control_q[ENABLE_BIT] && $fell(tap) && $stable({useLow, rate}))
    |=> timeBaseInterrupt)
    else $error("falling tap edge gave no interrupt");

  a_sel_gate: assert property (@(posedge clk) disable iff (rst)
    !$stable({useLow, rate}) |=> !timeBaseInterrupt)
    else $error("interrupt from a tap source switch");

  a_pulse_single: assert property (@(posedge clk) disable iff (rst)
    timeBaseInterrupt |=> !timeBaseInterrupt)
    else $error("interrupt pulse longer than one cycle");

  a_div_free: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> highDiv_q == $past(highDiv_q) + DIV_W'(1))
    else $error("divider disturbed");

  a_low_step: assert property (@(posedge clk) disable iff (rst)
    $changed(lowDiv_q) |-> lowDiv_q == $past(lowDiv_q) + DIV_W'(1))
    else $error("low divider jumped");

  a_div_read: assert property (@(posedge clk) disable iff (rst)
    ((read || write) && !busy_q && address == OFF_DIVIDER)
    |=> readdata == {9'h0, $past(highDiv_q)})
    else $error("divider readback wrong");

  a_ctrl_write: assert property (@(posedge clk) disable iff (rst)
    (accept && write && byteenable[0] && address == OFF_CONTROL)
    |=> control_q == $past(writedata[7:0]))
    else $error("control write lost");

  a_ctrl_hold: assert property (@(posedge clk) disable iff (rst)
    !(accept && write) |=> $stable(control_q))
    else $error("control changed without a write");

  a_be_ignored: assert property (@(posedge clk) disable iff (rst)
    (accept && write && !byteenable[0]) |=> $stable(control_q))
    else $error("write without lane zero landed");

  a_ctrl_read: assert property (@(posedge clk) disable iff (rst)
    ((read || write) && !busy_q && address == OFF_CONTROL)
    |=> readdata == {24'h0, $past(control_q)} && response == 2'h0)
    else $error("control readback wrong");

  // answer one cycle after the request
  a_wait_answer: assert property (@(posedge clk) disable iff (rst)
    ((read || write) && !busy_q) |=> !waitrequest)
    else $error("no answer to a request");

  a_wait_single: assert property (@(posedge clk) disable iff (rst)
    !waitrequest |=> waitrequest)
    else $error("waitrequest low too long");

  // fastest high tap at code 7
  a_high_tap: assert property (@(posedge clk) disable iff (rst)
    (!useLow && rate == 3'h7) |-> tap == highDiv_q[8])
    else $error("wrong high tap");

  a_high_code6: assert property (@(posedge clk) disable iff (rst)
    (!useLow && rate == 3'h6) |-> tap == highDiv_q[10])
    else $error("wrong high tap for code 6");

  a_slow_rate: assert property (@(posedge clk) disable iff (rst)
    mode_q[1] |-> (rate <= 3'h1 && tap == lowDiv_q[LOW_EXP[rate]-1]))
    else $error("slow mode tap wrong");

  // slow and sleep run from the low clock
  a_slow_low: assert property (@(posedge clk) disable iff (rst)
    mode_q[1] |-> useLow)
    else $error("slow mode on the high clock");

  // low clock halved at code 7
  a_low_tap: assert property (@(posedge clk) disable iff (rst)
    (useLow && rate == 3'h7) |-> tap == lowDiv_q[0])
    else $error("wrong low tap");

  a_prescale_tap: assert property (@(posedge clk) disable iff (rst)
    (control_q[PRESCALE_BIT] && !mode_q[1] && rate == 3'h6)
    |-> tap == lowDiv_q[2])
    else $error("wrong prescaled tap for code 6");

  a_mode_write: assert property (@(posedge clk) disable iff (rst)
    (accept && write && byteenable[0] && address == OFF_MODE)
    |=> mode_q == $past(writedata[1:0]))
    else $error("mode write lost");

  a_rate_enable: assert property (@(posedge clk) disable iff (rst)
    (accept && write && byteenable[0] && address == OFF_CONTROL
     && writedata[ENABLE_BIT])
    |=> control_q[ENABLE_BIT] && control_q[2:0] == $past(writedata[2:0]))
    else $error("combined write not applied");

  a_status_set: assert property (@(posedge clk) disable iff (rst)
    timeBaseInterrupt |=> status_q[0])
    else $error("pulse not latched in status");

  a_status_keep: assert property (@(posedge clk) disable iff (rst)
    (status_q[0] && !(accept && read && address == OFF_STATUS))
    |=> status_q[0])
    else $error("status lost without a read");

  a_status_clear: assert property (@(posedge clk) disable iff (rst)
    (accept && read && address == OFF_STATUS && readdata[0]
     && !timeBaseInterrupt) |=> !status_q[0])
    else $error("status read did not clear");

  // level request follows status and mask
  a_irq_level: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> irq == $past(status_q[0] & mask_q[0]))
    else $error("irq does not follow status and mask");

  a_mask_write: assert property (@(posedge clk) disable iff (rst)
    (accept && write && byteenable[0] && address == OFF_MASK)
    |=> mask_q[0] == $past(writedata[0]))
    else $error("mask write lost");

endmodule // time_base_interrupt_timer

// file: verification/low_clock_source.sv
// free-running low frequency clock source feeding the slow divider
module low_clock_source #(
  parameter int HALF_NS = 70
) (
  output logic lowClockTick
);
  timeunit 1ns;
  timeprecision 1ps;
  initial lowClockTick = 1'h0;
  // oscillator runs free, edges fall on falling system clock edges, between rising ones
  always #(HALF_NS) lowClockTick = ~lowClockTick;
endmodule // low_clock_source

// file: verification/time_base_interrupt_timer_tb.sv
// self-checking bench for the time base interrupt timer
module time_base_interrupt_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import time_base_pkg::*;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic read = 1'h0;
  logic write = 1'h0;
  logic lowClockTick, irq, timeBaseInterrupt, waitrequest;
  logic [7:0] address = 8'h00;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, q;
  logic [3:0] byteenable = 4'h1;
  logic [1:0] response, r;
  int numErrors = 0;
  int nChecks = 0;
  int n;
  always #5 clk = ~clk;
  // low tick period is 140 ns, fourteen system cycles
  low_clock_source lcs (.lowClockTick(lowClockTick));
  time_base_interrupt_timer DUT (.clk(clk), .rst(rst),
    .lowClockTick(lowClockTick), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .response(response),
    .timeBaseInterrupt(timeBaseInterrupt), .irq(irq));
  task automatic completeRun;
    if (numErrors == 0 && nChecks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    nChecks++;
    if (s !== e) begin
      numErrors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, d);
    @(posedge clk);
    address <= a;
    writedata <= {24'h0, d};
    write <= w;
    read <= !w;
    @(posedge clk);
    // wait as long as the slave asks; only the watchdog ends a hang
    while (waitrequest !== 1'h0) begin
      @(posedge clk);
    end
    q = readdata;
    r = response;
    read <= 1'h0;
    write <= 1'h0;
  endtask
  task automatic gap(input int lim);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (timeBaseInterrupt !== 1'h1 && n < lim);
  endtask
  // enable and rate in one write, then first pulse and exact period
  task automatic run(input logic [7:0] ctl, input int per);
    acc(1'h1, OFF_CONTROL, ctl);
    gap(per + 8);
    chk("first", 32'(n <= per + 4), 32'h1);
    gap(per + 8);
    chk("period", n, per);
    acc(1'h1, OFF_CONTROL, ctl & 8'hf7);
  endtask
  task automatic irq_test;
    acc(1'h1, OFF_MASK, 8'h01);
    acc(1'h1, OFF_CONTROL, 8'h0f);
    gap(520);
    repeat (4) @(posedge clk);
    chk("irqSet", irq, 1'h1);
    acc(1'h0, OFF_STATUS, 8'h00);
    chk("status", q, 32'h1);
    repeat (3) @(posedge clk);
    chk("irqClear", irq, 1'h0);
    acc(1'h1, OFF_MASK, 8'h00);
    gap(520);
    repeat (4) @(posedge clk);
    chk("irqMasked", irq, 1'h0);
    acc(1'h1, OFF_CONTROL, 8'h07);
  endtask
  // reset value, decode error, lane gating
  task automatic reg_test;
    acc(1'h0, OFF_CONTROL, 8'h00);
    chk("ctlReset", q, 32'h0);
    acc(1'h0, 8'h10, 8'h00);
    chk("unmappedResp", r, 2'h3);
    chk("unmappedData", q, 32'h0);
    byteenable <= 4'h0;
    acc(1'h1, OFF_CONTROL, 8'h0f);
    byteenable <= 4'h1;
    acc(1'h0, OFF_CONTROL, 8'h00);
    chk("laneOff", q, 32'h0);
  endtask
  task automatic rate_test;
    for (int c = 7; c > 4; c--)
      run({5'h01, 3'(c)}, 1 << HIGH_EXP[c]);
    for (int c = 7; c > 5; c--)
      run({5'h03, 3'(c)}, 14 << LOW_EXP[c]);
    acc(1'h0, OFF_CONTROL, 8'h00);
    chk("ctlBack", q, 32'h16);
    gap(1100);
    chk("disabled", n, 1100);
  endtask
  // slow mode: code 7 is not the fast low tap, so no pulse soon
  task automatic slow_test;
    acc(1'h1, OFF_MODE, 8'(MODE_SLOW));
    acc(1'h0, OFF_MODE, 8'h00);
    chk("modeSlow", q, 32'(MODE_SLOW));
    acc(1'h1, OFF_CONTROL, 8'h1f);
    gap(600);
    chk("slowCode7", n, 600);
    acc(1'h1, OFF_CONTROL, 8'h17);
    acc(1'h1, OFF_MODE, 8'(MODE_NORMAL));
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    reg_test();
    rate_test();
    slow_test();
    irq_test();
    completeRun();
  end
  // the run needs about 15k cycles; the limit leaves ample margin
  initial begin
    #500us;
    numErrors++;
    completeRun();
  end
endmodule // time_base_interrupt_timer_tb
